// *** hw/tpg_pkg.sv ***
// package: register map, field layout and pattern codes of the test pattern generator
package tpg_pkg;
  localparam int unsigned PIX_W = 12;
  localparam int unsigned COL_W = 12;
  localparam int unsigned ROW_W = 12;
  localparam int unsigned MEM_AW = 12;
  // register byte offsets
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_WIDTH = 8'h04;
  localparam logic [7:0] REG_HEIGHT = 8'h08;
  localparam logic [7:0] REG_STATUS = 8'h0C;
  localparam logic [7:0] REG_FCOUNT = 8'h10;
  // field positions
  localparam int unsigned CTRL_SEL_LSB = 0;
  localparam int unsigned CTRL_SEL_W = 3;
  localparam int unsigned CTRL_FTRIG_EXT_BIT = 4;
  localparam int unsigned CTRL_LTRIG_EXT_BIT = 5;
  // reset values
  localparam logic [2:0] SEL_RST = 3'h0;
  localparam logic [COL_W-1:0] WIDTH_RST = 12'h100;
  localparam logic [ROW_W-1:0] HEIGHT_RST = 12'h010;
  // read answer for unmapped addresses
  localparam logic [31:0] UNMAPPED_DATA = 32'h0000_0000;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {
    TPG_PAT_OFF = 3'b000,
    TPG_PAT_STATIC8 = 3'b001,
    TPG_PAT_MOVE8 = 3'b010,
    TPG_PAT_MOVE12 = 3'b011,
    TPG_PAT_FEAT8 = 3'b100,
    TPG_PAT_FEAT12 = 3'b101
  } tpg_pat_t;

  typedef enum logic [1:0] {
    TPG_ST_IDLE = 2'b00,
    TPG_ST_WAIT_LINE = 2'b01,
    TPG_ST_LINE = 2'b10,
    TPG_ST_SEND = 2'b11
  } tpg_state_t;
endpackage

// *** hw/tpg_line_mem.sv ***
// frame memory: one word per pixel, registered read port
`timescale 1ns/1ps
module tpg_line_mem (
  // clock
  input  wire logic                          clk_sys,
  // write port
  input  wire logic                          wr_en,
  input  wire logic [tpg_pkg::MEM_AW-1:0]    wr_addr,
  input  wire logic [tpg_pkg::PIX_W:0]       wr_data,
  // read port
  input  wire logic [tpg_pkg::MEM_AW-1:0]    rd_addr,
  output logic      [tpg_pkg::PIX_W:0]       rd_data
);
  logic [tpg_pkg::PIX_W:0] mem [0:(1<<tpg_pkg::MEM_AW)-1];

  // storage has no reset, content is only read after a full frame is written
  always_ff @(posedge clk_sys) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
    rd_data <= mem[rd_addr];
  end
endmodule

// *** hw/tpg_top.sv ***
// test pattern generator: pattern synthesis, frame memory fill and frame output
//
// The address map and register access over AXI4-Lite are this design's own decisions.
`timescale 1ns/1ps
module tpg_top (
  // clock and reset
  input  wire logic                          clk_sys,
  input  wire logic                          sys_rst,
  // axi4-lite write address
  input  wire logic                          s_axi_awvalid,
  output logic                               s_axi_awready,
  input  wire logic [7:0]                    s_axi_awaddr,
  // axi4-lite write data
  input  wire logic                          s_axi_wvalid,
  output logic                               s_axi_wready,
  input  wire logic [31:0]                   s_axi_wdata,
  input  wire logic [3:0]                    s_axi_wstrb,
  // axi4-lite write response
  output logic                               s_axi_bvalid,
  input  wire logic                          s_axi_bready,
  output logic      [1:0]                    s_axi_bresp,
  // axi4-lite read address
  input  wire logic                          s_axi_arvalid,
  output logic                               s_axi_arready,
  input  wire logic [7:0]                    s_axi_araddr,
  // axi4-lite read data
  output logic                               s_axi_rvalid,
  input  wire logic                          s_axi_rready,
  output logic      [31:0]                   s_axi_rdata,
  output logic      [1:0]                    s_axi_rresp,
  // triggers, internal or from input lines
  input  wire logic                          frame_trig_int,
  input  wire logic                          frame_trig_ext,
  input  wire logic                          line_trig_int,
  input  wire logic                          line_trig_ext,
  // sensor path after analog stage
  input  wire logic                          sens_valid,
  input  wire logic [tpg_pkg::PIX_W-1:0]     sens_data,
  input  wire logic                          sens_sof,
  // toward the digital processing chain
  output logic                               proc_valid,
  output logic      [tpg_pkg::PIX_W-1:0]     proc_data,
  output logic                               proc_sof,
  // processed data returning from the chain
  input  wire logic                          proc_ret_valid,
  input  wire logic [tpg_pkg::PIX_W-1:0]     proc_ret_data,
  input  wire logic                          proc_ret_sof,
  // image output toward transmission
  output logic                               out_valid,
  output logic      [tpg_pkg::PIX_W-1:0]     out_data,
  output logic                               out_sof,
  output logic                               out_eof,
  // test mode active
  output logic                               test_active
);
  // ---------------- register file ----------------
  logic [2:0]               sel_q, sel_d;
  logic                     ftrig_ext_q, ftrig_ext_d;
  logic                     ltrig_ext_q, ltrig_ext_d;
  logic [tpg_pkg::COL_W-1:0] width_q, width_d;
  logic [tpg_pkg::ROW_W-1:0] height_q, height_d;
  logic                     bvalid_q, bvalid_d;
  logic [1:0]               bresp_q, bresp_d;
  logic                     rvalid_q, rvalid_d;
  logic [31:0]              rdata_q, rdata_d;
  logic [1:0]               rresp_q, rresp_d;
  logic                     wr_fire, rd_fire;

  // frame side state, declared early for status reads
  tpg_pkg::tpg_state_t      st_q, st_d;
  tpg_pkg::tpg_pat_t        pat_q, pat_d;
  logic [tpg_pkg::COL_W-1:0] col_q, col_d;
  logic [tpg_pkg::ROW_W-1:0] row_q, row_d;
  logic [tpg_pkg::PIX_W-1:0] fcnt_q, fcnt_d;

  // address and data taken together, one write in flight at a time
  assign s_axi_awready = s_axi_awvalid && s_axi_wvalid && !bvalid_q;
  assign s_axi_wready  = s_axi_awready;
  assign wr_fire       = s_axi_awready;
  assign s_axi_arready = s_axi_arvalid && !rvalid_q;
  assign rd_fire       = s_axi_arready;
  assign s_axi_bvalid  = bvalid_q;
  assign s_axi_bresp   = bresp_q;
  assign s_axi_rvalid  = rvalid_q;
  assign s_axi_rdata   = rdata_q;
  assign s_axi_rresp   = rresp_q;

  // register write and read decode
  always_comb begin
    sel_d       = sel_q;
    ftrig_ext_d = ftrig_ext_q;
    ltrig_ext_d = ltrig_ext_q;
    width_d     = width_q;
    height_d    = height_q;
    bvalid_d    = bvalid_q && !s_axi_bready;
    bresp_d     = bresp_q;
    rvalid_d    = rvalid_q && !s_axi_rready;
    rdata_d     = rdata_q;
    rresp_d     = rresp_q;
    if (wr_fire) begin
      bvalid_d = 1'b1;
      bresp_d  = tpg_pkg::RESP_OKAY;
      unique case (s_axi_awaddr)
        tpg_pkg::REG_CTRL: begin
          if (s_axi_wstrb[0]) begin
            sel_d       = s_axi_wdata[tpg_pkg::CTRL_SEL_LSB +: tpg_pkg::CTRL_SEL_W];
            ftrig_ext_d = s_axi_wdata[tpg_pkg::CTRL_FTRIG_EXT_BIT];
            ltrig_ext_d = s_axi_wdata[tpg_pkg::CTRL_LTRIG_EXT_BIT];
          end
        end
        tpg_pkg::REG_WIDTH: begin
          if (s_axi_wstrb[0]) width_d[7:0] = s_axi_wdata[7:0];
          if (s_axi_wstrb[1]) width_d[11:8] = s_axi_wdata[11:8];
        end
        tpg_pkg::REG_HEIGHT: begin
          if (s_axi_wstrb[0]) height_d[7:0] = s_axi_wdata[7:0];
          if (s_axi_wstrb[1]) height_d[11:8] = s_axi_wdata[11:8];
        end
        tpg_pkg::REG_STATUS, tpg_pkg::REG_FCOUNT: ; // read only, write ignored
        default: bresp_d = tpg_pkg::RESP_SLVERR;
      endcase
    end
    if (rd_fire) begin
      rvalid_d = 1'b1;
      rresp_d  = tpg_pkg::RESP_OKAY;
      unique case (s_axi_araddr)
        tpg_pkg::REG_CTRL:   rdata_d = {26'h0, ltrig_ext_q, ftrig_ext_q, 1'b0, sel_q};
        tpg_pkg::REG_WIDTH:  rdata_d = {20'h0, width_q};
        tpg_pkg::REG_HEIGHT: rdata_d = {20'h0, height_q};
        tpg_pkg::REG_STATUS: rdata_d = {25'h0, pat_q, 2'h0, st_q};
        tpg_pkg::REG_FCOUNT: rdata_d = {20'h0, fcnt_q};
        default: begin
          rdata_d = tpg_pkg::UNMAPPED_DATA;
          rresp_d = tpg_pkg::RESP_SLVERR;
        end
      endcase
    end
  end

  // register bank flops
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      sel_q       <= tpg_pkg::SEL_RST;
      ftrig_ext_q <= 1'b0;
      ltrig_ext_q <= 1'b0;
      width_q     <= tpg_pkg::WIDTH_RST;
      height_q    <= tpg_pkg::HEIGHT_RST;
      bvalid_q    <= 1'b0;
      bresp_q     <= 2'h0;
      rvalid_q    <= 1'b0;
      rdata_q     <= 32'h0000_0000;
      rresp_q     <= 2'h0;
    end else begin
      sel_q       <= sel_d;
      ftrig_ext_q <= ftrig_ext_d;
      ltrig_ext_q <= ltrig_ext_d;
      width_q     <= width_d;
      height_q    <= height_d;
      bvalid_q    <= bvalid_d;
      bresp_q     <= bresp_d;
      rvalid_q    <= rvalid_d;
      rdata_q     <= rdata_d;
      rresp_q     <= rresp_d;
    end
  end

  // ---------------- frame generator ----------------
  logic                         frame_trig, line_trig;
  logic                         mem_we;
  logic [tpg_pkg::MEM_AW-1:0]   wr_addr, rd_addr_q, rd_addr_d;
  logic [tpg_pkg::PIX_W-1:0]    gen_pix, sum;
  logic                         feat_path;
  logic [tpg_pkg::PIX_W:0]      rd_word;
  logic                         send_v_q, send_v_d, send_sof_q, send_sof_d;
  logic                         send_eof_q, send_eof_d;
  logic [tpg_pkg::MEM_AW-1:0]   send_cnt_q, send_cnt_d, frame_px;
  logic [2*tpg_pkg::COL_W-1:0]  frame_px_full;
  logic                         is_pattern;

  // trigger source picked per trigger type
  assign frame_trig = ftrig_ext_q ? frame_trig_ext : frame_trig_int;
  assign line_trig  = ltrig_ext_q ? line_trig_ext : line_trig_int;
  assign is_pattern = (sel_q >= 3'h1) && (sel_q <= 3'h5);

  // pixel value: index sum, counter added for moving patterns
  always_comb begin
    sum = col_q + row_q;
    unique case (pat_q)
      tpg_pkg::TPG_PAT_STATIC8: gen_pix = {4'h0, sum[7:0]};
      tpg_pkg::TPG_PAT_MOVE8, tpg_pkg::TPG_PAT_FEAT8: begin
        gen_pix = {4'h0, sum[7:0] + fcnt_q[7:0]};
      end
      tpg_pkg::TPG_PAT_MOVE12, tpg_pkg::TPG_PAT_FEAT12: begin
        gen_pix = sum + fcnt_q; // modulo 4096 by width
      end
      default: gen_pix = 12'h000;
    endcase
  end
  assign feat_path = (pat_q == tpg_pkg::TPG_PAT_FEAT8) || (pat_q == tpg_pkg::TPG_PAT_FEAT12);

  // index of the last pixel, clamped to the memory depth; a full 4096 frame keeps every pixel
  assign frame_px_full = width_q * height_q;
  assign frame_px = (frame_px_full > 24'h001000) ? 12'hFFF : frame_px_full[11:0] - 12'h001;
  assign wr_addr  = rd_addr_q;
  assign mem_we   = (st_q == tpg_pkg::TPG_ST_LINE);

  // sequencing: wait frame trigger, fill lines on line triggers, then send
  always_comb begin
    st_d       = st_q;
    pat_d      = pat_q;
    col_d      = col_q;
    row_d      = row_q;
    fcnt_d     = fcnt_q;
    rd_addr_d  = rd_addr_q;
    send_cnt_d = send_cnt_q;
    send_v_d   = 1'b0;
    send_sof_d = 1'b0;
    send_eof_d = 1'b0;
    unique case (st_q)
      tpg_pkg::TPG_ST_IDLE: begin
        if (frame_trig && is_pattern) begin
          pat_d     = tpg_pkg::tpg_pat_t'(sel_q); // latched per frame
          fcnt_d    = fcnt_q + 12'h001;
          col_d     = 12'h000;
          row_d     = 12'h000;
          rd_addr_d = 12'h000;
          st_d      = tpg_pkg::TPG_ST_WAIT_LINE;
        end
      end
      tpg_pkg::TPG_ST_WAIT_LINE: begin
        if (line_trig) st_d = tpg_pkg::TPG_ST_LINE;
      end
      tpg_pkg::TPG_ST_LINE: begin
        rd_addr_d = rd_addr_q + 12'h001;
        if (col_q == width_q - 12'h001 || rd_addr_q == frame_px) begin
          col_d = 12'h000;
          row_d = row_q + 12'h001;
          if (row_q == height_q - 12'h001 || rd_addr_q == frame_px) begin
            rd_addr_d  = 12'h000;
            send_cnt_d = 12'h000;
            st_d       = tpg_pkg::TPG_ST_SEND;
          end else begin
            st_d = tpg_pkg::TPG_ST_WAIT_LINE;
          end
        end else begin
          col_d = col_q + 12'h001;
        end
      end
      tpg_pkg::TPG_ST_SEND: begin
        // memory read is one cycle late, so valid trails the address
        rd_addr_d  = rd_addr_q + 12'h001;
        send_cnt_d = send_cnt_q + 12'h001;
        send_v_d   = 1'b1;
        send_sof_d = (send_cnt_q == 12'h000);
        send_eof_d = (send_cnt_q == frame_px);
        if (send_cnt_q == frame_px) st_d = tpg_pkg::TPG_ST_IDLE;
      end
    endcase
  end

  // generator flops
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      st_q       <= tpg_pkg::TPG_ST_IDLE;
      pat_q      <= tpg_pkg::TPG_PAT_OFF;
      col_q      <= 12'h000;
      row_q      <= 12'h000;
      fcnt_q     <= 12'h000;
      rd_addr_q  <= 12'h000;
      send_cnt_q <= 12'h000;
      send_v_q   <= 1'b0;
      send_sof_q <= 1'b0;
      send_eof_q <= 1'b0;
    end else begin
      st_q       <= st_d;
      pat_q      <= pat_d;
      col_q      <= col_d;
      row_q      <= row_d;
      fcnt_q     <= fcnt_d;
      rd_addr_q  <= rd_addr_d;
      send_cnt_q <= send_cnt_d;
      send_v_q   <= send_v_d;
      send_sof_q <= send_sof_d;
      send_eof_q <= send_eof_d;
    end
  end

  // frame memory holds pixel plus its processing route bit
  tpg_line_mem u_mem (
    .clk_sys (clk_sys),
    .wr_en   (mem_we),
    .wr_addr (wr_addr),
    .wr_data ({feat_path, gen_pix}),
    .rd_addr (rd_addr_q),
    .rd_data (rd_word)
  );

  // ---------------- output routing ----------------
  logic                      pv_q, pv_d, psof_q, psof_d;
  logic [tpg_pkg::PIX_W-1:0] pdat_q, pdat_d;
  logic                      ov_q, ov_d, osof_q, osof_d, oeof_q, oeof_d;
  logic [tpg_pkg::PIX_W-1:0] odat_q, odat_d;
  logic                      test_q, test_d;

  // test mode replaces sensor data; analog settings act upstream of here
  always_comb begin
    test_d = is_pattern || (st_q != tpg_pkg::TPG_ST_IDLE);
    pv_d   = 1'b0;
    psof_d = 1'b0;
    pdat_d = pdat_q;
    ov_d   = 1'b0;
    osof_d = 1'b0;
    oeof_d = 1'b0;
    odat_d = odat_q;
    if (test_q) begin
      if (send_v_q && rd_word[tpg_pkg::PIX_W]) begin
        pv_d   = 1'b1;
        psof_d = send_sof_q;
        pdat_d = rd_word[tpg_pkg::PIX_W-1:0];
      end else if (send_v_q) begin
        ov_d   = 1'b1;                          // bypass processing
        osof_d = send_sof_q;
        oeof_d = send_eof_q;
        odat_d = rd_word[tpg_pkg::PIX_W-1:0];   // no analog term
      end
      if (proc_ret_valid) begin
        ov_d   = 1'b1;
        osof_d = proc_ret_sof;
        oeof_d = 1'b0;
        odat_d = proc_ret_data;
      end
    end else begin
      pv_d   = sens_valid;                      // sensor only when off
      psof_d = sens_valid && sens_sof;          // no frame start on an empty slot
      pdat_d = sens_data;
      if (proc_ret_valid) begin
        ov_d   = 1'b1;
        osof_d = proc_ret_sof;
        odat_d = proc_ret_data;
      end
    end
  end

  // output flops
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      pv_q   <= 1'b0;
      psof_q <= 1'b0;
      pdat_q <= 12'h000;
      ov_q   <= 1'b0;
      osof_q <= 1'b0;
      oeof_q <= 1'b0;
      odat_q <= 12'h000;
      test_q <= 1'b0;
    end else begin
      pv_q   <= pv_d;
      psof_q <= psof_d;
      pdat_q <= pdat_d;
      ov_q   <= ov_d;
      osof_q <= osof_d;
      oeof_q <= oeof_d;
      odat_q <= odat_d;
      test_q <= test_d;
    end
  end

  assign proc_valid  = pv_q;
  assign proc_sof    = psof_q;
  assign proc_data   = pdat_q;
  assign out_valid   = ov_q;
  assign out_sof     = osof_q;
  assign out_eof     = oeof_q;
  assign out_data    = odat_q;
  assign test_active = test_q;
endmodule

// *** bench/tpg_chk.sv ***
// checker: bus answers and output framing of the test pattern generator
`timescale 1ns/1ps
module tpg_chk (
  // clock and reset
  input wire logic        clk_sys,
  input wire logic        sys_rst,
  // register bus
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  // streams
  input wire logic        sens_valid,
  input wire logic        proc_valid,
  input wire logic        proc_sof,
  input wire logic        out_valid,
  input wire logic        out_sof,
  input wire logic        out_eof,
  input wire logic        test_active
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  // a request is taken when offered and no answer is pending
  sequence s_wr_take;
    s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid;
  endsequence
  sequence s_rd_take;
    s_axi_arvalid && !s_axi_rvalid;
  endsequence
  a_wr_answer: assert property (s_wr_take |=> s_axi_bvalid)
    else $error("write answer missing");
  a_wr_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write answer dropped early");
  a_rd_answer: assert property (s_rd_take |=> s_axi_rvalid)
    else $error("read answer missing");
  a_rd_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read answer dropped early");
  a_ready_pair: assert property (s_axi_awready |-> s_axi_wready && s_axi_wvalid && !s_axi_bvalid)
    else $error("write readies not paired");
  // with test mode off, sensor pixels reach the chain one cycle later
  a_sensor_pass: assert property (!test_active && !$past(test_active) && !$past(sys_rst)
    |-> proc_valid == $past(sens_valid))
    else $error("sensor pixel not passed while off");
  a_sof_valid: assert property (out_sof |-> out_valid)
    else $error("frame start without pixel");
  a_proc_sof: assert property (proc_sof |-> proc_valid)
    else $error("chain start without pixel");
  // a new frame needs a fresh trigger, so the stream pauses after the last pixel
  a_eof_gap: assert property (out_eof |-> out_valid ##1 !out_valid [*2])
    else $error("stream continues past frame end");
endmodule

bind tpg_top tpg_chk tpg_chk_inst (
  .clk_sys(clk_sys), .sys_rst(sys_rst), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .s_axi_rdata(s_axi_rdata), .sens_valid(sens_valid), .proc_valid(proc_valid), .proc_sof(proc_sof),
  .out_valid(out_valid), .out_sof(out_sof), .out_eof(out_eof), .test_active(test_active)
);

// *** bench/tpg_chain_model.sv ***
// processing chain stand-in: two-stage pipeline adding a fixed offset
`timescale 1ns/1ps
module tpg_chain_model #(
  parameter logic [11:0] OFFSET = 12'h010
) (
  // clock and reset
  input wire logic        clk_sys,
  input wire logic        sys_rst,
  // from the generator
  input wire logic        proc_valid,
  input wire logic [11:0] proc_data,
  input wire logic        proc_sof,
  // back to the generator
  output logic            proc_ret_valid,
  output logic [11:0]     proc_ret_data,
  output logic            proc_ret_sof
);
  logic        v_q;
  logic        s_q;
  logic [11:0] d_q;
  // idle data inverts every cycle so a stale value never passes for a pixel
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      v_q <= 1'b0;
      s_q <= 1'b0;
      d_q <= 12'h000;
      proc_ret_valid <= 1'b0;
      proc_ret_sof <= 1'b0;
      proc_ret_data <= 12'h000;
    end else begin
      v_q <= proc_valid;
      s_q <= proc_valid && proc_sof;
      d_q <= proc_valid ? proc_data + OFFSET : ~d_q;
      proc_ret_valid <= v_q;
      proc_ret_sof <= s_q;
      proc_ret_data <= d_q;
    end
  end
endmodule

// *** bench/tpg_top_bench.sv ***
// bench: drives the generator over axi4-lite and checks whole frames
`timescale 1ns/1ps
module tpg_top_bench;
  localparam logic [11:0] OFF = 12'h010;
  localparam int W = 250;
  localparam int H = 3;
  logic clk_sys, sys_rst, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic frame_trig_int, frame_trig_ext, line_trig_int, line_trig_ext;
  logic sens_valid, sens_sof, proc_valid, proc_sof, proc_ret_valid, proc_ret_sof;
  logic out_valid, out_sof, out_eof, test_active;
  logic [11:0] sens_data, proc_data, proc_ret_data, out_data;
  logic [11:0] q_d[$];
  logic q_s[$];
  logic q_e[$];
  int n_fail, n_tests, cnt;

  tpg_top tpg_top_inst (.clk_sys(clk_sys), .sys_rst(sys_rst), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_awaddr(s_axi_awaddr), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_araddr(s_axi_araddr),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .frame_trig_int(frame_trig_int), .frame_trig_ext(frame_trig_ext),
    .line_trig_int(line_trig_int), .line_trig_ext(line_trig_ext), .sens_valid(sens_valid),
    .sens_data(sens_data), .sens_sof(sens_sof), .proc_valid(proc_valid), .proc_data(proc_data),
    .proc_sof(proc_sof), .proc_ret_valid(proc_ret_valid), .proc_ret_data(proc_ret_data),
    .proc_ret_sof(proc_ret_sof), .out_valid(out_valid), .out_data(out_data), .out_sof(out_sof),
    .out_eof(out_eof), .test_active(test_active));
  tpg_chain_model #(.OFFSET(OFF)) tpg_chain_model_inst (.clk_sys(clk_sys), .sys_rst(sys_rst),
    .proc_valid(proc_valid), .proc_data(proc_data), .proc_sof(proc_sof),
    .proc_ret_valid(proc_ret_valid), .proc_ret_data(proc_ret_data), .proc_ret_sof(proc_ret_sof));

  // clock and busy sensor noise that a test frame must never show
  always #25 clk_sys = ~clk_sys;
  always @(posedge clk_sys) begin
    sens_data <= sens_data + 12'h3A7;
    sens_sof <= (sens_data[3:0] == 4'h0);
  end
  // capture every output pixel
  always @(posedge clk_sys) begin
    if (out_valid === 1'b1) begin
      q_d.push_back(out_data);
      q_s.push_back(out_sof);
      q_e.push_back(out_eof);
    end
  end

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  // bus waits have no limit of their own, the watchdog ends a hang
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge clk_sys);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge clk_sys);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge clk_sys);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge clk_sys);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  task automatic pulse(input int k);
    @(posedge clk_sys);
    case (k)
      0: frame_trig_int <= 1'b1;
      1: frame_trig_ext <= 1'b1;
      2: line_trig_int <= 1'b1;
      default: line_trig_ext <= 1'b1;
    endcase
    @(posedge clk_sys);
    {frame_trig_int, frame_trig_ext, line_trig_int, line_trig_ext} <= 4'h0;
  endtask

  // reset values, unmapped place, read-only counter, frame size
  task automatic t_regs;
    logic [31:0] d;
    logic [1:0] r;
    rd(tpg_pkg::REG_WIDTH, d, r);
    chk("width", 32'h100, d);
    rd(tpg_pkg::REG_HEIGHT, d, r);
    chk("height", 32'h010, d);
    rd(tpg_pkg::REG_CTRL, d, r);
    chk("select", 32'h0, d);
    rd(8'h20, d, r);
    chk("unmapped resp", tpg_pkg::RESP_SLVERR, r);
    wr(tpg_pkg::REG_FCOUNT, 32'hFFF, r);
    chk("write resp", tpg_pkg::RESP_OKAY, r);
    rd(tpg_pkg::REG_FCOUNT, d, r);
    chk("counter", 32'h0, d);
    wr(tpg_pkg::REG_WIDTH, W, r);
    wr(tpg_pkg::REG_HEIGHT, H, r);
    rd(tpg_pkg::REG_WIDTH, d, r);
    chk("width set", W, d);
    $display("test registers done");
  endtask

  // one frame with selection sel; mid is written while the frame runs
  task automatic t_frame(input logic [2:0] sel, input logic ext, input logic [2:0] mid);
    logic [31:0] d;
    logic [1:0] r;
    int v, n;
    // sensor paused over the switch so no in-flight sensor pixel lands in the capture
    sens_valid <= 1'b0;
    wr(tpg_pkg::REG_CTRL, {26'h0, ext, ext, 1'b0, sel}, r);
    repeat (4) @(posedge clk_sys);
    chk("test mode", sel != 3'h0, test_active);
    q_d.delete();
    q_s.delete();
    q_e.delete();
    sens_valid <= (sel != 3'h0);
    if (ext) begin
      pulse(0);
      repeat (5) @(posedge clk_sys);
      rd(tpg_pkg::REG_STATUS, d, r);
      chk("state", 32'h0, {30'h0, d[1:0]});
    end
    pulse(ext ? 1 : 0);
    wr(tpg_pkg::REG_CTRL, {26'h0, ext, ext, 1'b0, mid}, r);
    for (n = 0; n < H; n++) begin
      pulse(ext ? 3 : 2);
      repeat (W + 4) @(posedge clk_sys);
    end
    // test mode ends with this frame, so the sensor must not refill the capture
    if (mid == 3'h0) sens_valid <= 1'b0;
    if (sel != 3'h0) cnt++;
    n = 0;
    while (q_d.size() < W * H && sel != 3'h0 && n < 5000) begin
      @(posedge clk_sys);
      n++;
    end
    repeat (20) @(posedge clk_sys);
    chk("pixel count", (sel == 3'h0) ? 0 : W * H, q_d.size());
    for (n = 0; n < q_d.size() && n < W * H; n++) begin
      v = n % W + n / W + ((sel == 3'h1) ? 0 : cnt);
      v = (sel == 3'h3 || sel == 3'h5) ? v % 4096 : v % 256;
      if (sel >= 3'h4) v = (v + OFF) % 4096;
      chk("pixel", v, q_d[n]);
      chk("sof", n == 0, q_s[n]);
      if (sel < 3'h4) chk("eof", n == W * H - 1, q_e[n]);
    end
    rd(tpg_pkg::REG_FCOUNT, d, r);
    chk("frame counter", cnt, d);
    $display("test frame pattern %0d done", sel);
  endtask

  task automatic summarize;
    $display("comparisons %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  // hang guard, well past the roughly nine thousand cycles of the run
  initial begin
    #(40000 * 50);
    n_fail++;
    summarize();
  end
  initial begin
    clk_sys = 1'b0;
    sys_rst = 1'b1;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    s_axi_awaddr = 8'h00;
    s_axi_araddr = 8'h00;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'hF;
    {frame_trig_int, frame_trig_ext, line_trig_int, line_trig_ext} = 4'h0;
    sens_valid = 1'b1;
    sens_data = 12'h000;
    sens_sof = 1'b0;
    n_fail = 0;
    n_tests = 0;
    cnt = 0;
    repeat (12) @(posedge clk_sys);
    sys_rst <= 1'b0;
    t_regs();
    t_frame(3'h0, 1'b0, 3'h0);
    t_frame(3'h1, 1'b0, 3'h3);
    t_frame(3'h2, 1'b0, 3'h0);
    t_frame(3'h3, 1'b1, 3'h5);
    t_frame(3'h4, 1'b0, 3'h1);
    t_frame(3'h5, 1'b1, 3'h2);
    summarize();
  end
endmodule
